// ---- common/alu_pkg.sv ----
package alu_pkg;

  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;

  localparam logic [1:0] CLK_SHORT = 2'h1;
  localparam logic [1:0] CLK_TWO   = 2'h2;
  localparam logic [1:0] CLK_CALL  = 2'h3;

  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] SREG_RST  = 8'h00;

  typedef enum logic [4:0] {
    op_add                    = 5'h00,
    op_add_carry              = 5'h01,
    op_sub_regs               = 5'h02,
    op_sub_const              = 5'h03,
    op_sub_regs_carry         = 5'h04,
    op_sub_const_carry        = 5'h05,
    op_add_imm_word           = 5'h06,
    op_sub_imm_word           = 5'h07,
    op_and_regs               = 5'h08,
    op_and_const              = 5'h09,
    op_or_regs                = 5'h0a,
    op_or_const               = 5'h0b,
    op_xor_regs               = 5'h0c,
    op_set_mask_bits          = 5'h0d,
    op_clear_mask_bits        = 5'h0e,
    op_test_zero_minus        = 5'h0f,
    op_mult_unsigned          = 5'h10,
    op_mult_signed            = 5'h11,
    op_mult_signed_unsigned   = 5'h12,
    op_frac_mult_unsigned     = 5'h13,
    op_frac_mult_signed       = 5'h14,
    op_frac_mult_signed_unsigned = 5'h15,
    op_relative_jump          = 5'h16,
    op_pointer_jump           = 5'h17,
    op_relative_call          = 5'h18
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [7:0]  dst;
    logic [7:0]  src;
    logic [7:0]  imm;
    logic [15:0] pair;
    logic [15:0] pc;
    logic [15:0] offs;
    logic [15:0] zptr;
    logic [7:0]  sreg;
  } req_t;

  typedef struct packed {
    logic [7:0]  dst_val;
    logic        wr_dst;
    logic [15:0] pair_val;
    logic        wr_pair;
    logic        wr_r1r0;
    logic [15:0] pc;
    logic        pc_load;
    logic [7:0]  sreg;
  } res_t;

endpackage

// ---- hw/alu_mult.sv ----
`timescale 1ns/10ps
module alu_mult (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_load,
  input  wire logic [7:0]  i_a,
  input  wire logic [7:0]  i_b,
  input  wire logic        i_a_signed,
  input  wire logic        i_b_signed,
  output logic      [15:0] o_prod
);
  logic signed [8:0]  a_ext;
  logic signed [8:0]  b_ext;
  logic signed [17:0] full;

  assign a_ext = $signed({i_a_signed & i_a[7], i_a});
  assign b_ext = $signed({i_b_signed & i_b[7], i_b});
  assign full  = a_ext * b_ext;

  // Product held for the second clock of the multiply
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prod <= 16'h0000;
    end else if (i_load) begin
      o_prod <= full[15:0];
    end
  end
endmodule // alu_mult

// ---- hw/eight_bit_alu_and_jumps.sv ----
`timescale 1ns/10ps
module eight_bit_alu_and_jumps #(
  parameter int unsigned PC_W = 12
) (
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_valid,
  input  wire alu_pkg::req_t i_req,
  output logic               o_ready,
  output logic               o_done,
  output alu_pkg::res_t      o_res
);
  // Elaboration check on the program counter width
  if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
    $error("PC_W must be 1..16");
  end

  logic          accept;
  logic          busy_ff;
  logic [1:0]    cnt_ff;
  alu_pkg::res_t pend_ff;
  logic          pend_mult_ff;
  logic          pend_frac_ff;
  logic [7:0]    pend_sreg_ff;
  alu_pkg::res_t nxt_res;
  logic [1:0]    nxt_clocks;
  logic          is_mult;
  logic          is_frac;
  logic          a_sgn;
  logic          b_sgn;
  logic [15:0]   prod;
  logic [15:0]   mres;
  logic [15:0]   pc_mask;

  assign accept  = i_valid & o_ready;
  assign pc_mask = 16'((17'h1 << PC_W) - 17'h1);

  always_comb begin
    is_mult = 1'b1;
    is_frac = 1'b0;
    a_sgn   = 1'b0;
    b_sgn   = 1'b0;
    case (i_req.op)
      alu_pkg::op_mult_unsigned:             ;
      alu_pkg::op_mult_signed:               begin a_sgn = 1'b1; b_sgn = 1'b1; end
      alu_pkg::op_mult_signed_unsigned:      a_sgn = 1'b1;
      alu_pkg::op_frac_mult_unsigned:        is_frac = 1'b1;
      alu_pkg::op_frac_mult_signed:          begin is_frac = 1'b1; a_sgn = 1'b1; b_sgn = 1'b1; end
      alu_pkg::op_frac_mult_signed_unsigned: begin is_frac = 1'b1; a_sgn = 1'b1; end
      default:                               is_mult = 1'b0;
    endcase
  end

  alu_mult u_mult (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_load     (accept & is_mult),
    .i_a        (i_req.dst),
    .i_b        (i_req.src),
    .i_a_signed (a_sgn),
    .i_b_signed (b_sgn),
    .o_prod     (prod)
  );

  // Byte, word and jump results for the request on the bus
  always_comb begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  r;
    logic [15:0] w;
    logic        cin;
    logic        sub;
    logic        arith;
    logic        logic_op;
    logic [7:0]  s;
    a        = i_req.dst;
    b        = i_req.src;
    r        = 8'h00;
    w        = 16'h0000;
    cin      = 1'b0;
    sub      = 1'b0;
    arith    = 1'b0;
    logic_op = 1'b0;
    s        = i_req.sreg;
    nxt_res  = '0;
    nxt_res.sreg = i_req.sreg;
    nxt_clocks   = alu_pkg::CLK_SHORT;
    case (i_req.op)
      alu_pkg::op_add:             arith = 1'b1;
      alu_pkg::op_add_carry:       begin arith = 1'b1; cin = s[alu_pkg::FLG_C]; end
      alu_pkg::op_sub_regs:        begin arith = 1'b1; sub = 1'b1; end
      alu_pkg::op_sub_const:       begin arith = 1'b1; sub = 1'b1; b = i_req.imm; end
      alu_pkg::op_sub_regs_carry:  begin arith = 1'b1; sub = 1'b1; cin = s[alu_pkg::FLG_C]; end
      alu_pkg::op_sub_const_carry: begin
        arith = 1'b1;
        sub   = 1'b1;
        b     = i_req.imm;
        cin   = s[alu_pkg::FLG_C];
      end
      alu_pkg::op_and_regs:        begin logic_op = 1'b1; r = a & b; end
      alu_pkg::op_and_const:       begin logic_op = 1'b1; r = a & i_req.imm; end
      alu_pkg::op_or_regs:         begin logic_op = 1'b1; r = a | b; end
      alu_pkg::op_or_const:        begin logic_op = 1'b1; r = a | i_req.imm; end
      alu_pkg::op_xor_regs:        begin logic_op = 1'b1; r = a ^ b; end
      alu_pkg::op_set_mask_bits:   begin logic_op = 1'b1; r = a | i_req.imm; end
      alu_pkg::op_clear_mask_bits: begin
        logic_op = 1'b1;
        r = a & (alu_pkg::BYTE_ONES - i_req.imm);
      end
      alu_pkg::op_test_zero_minus: begin logic_op = 1'b1; r = a & a; end
      alu_pkg::op_add_imm_word, alu_pkg::op_sub_imm_word: begin
        sub = (i_req.op == alu_pkg::op_sub_imm_word);
        w   = sub ? i_req.pair - {8'h00, i_req.imm} : i_req.pair + {8'h00, i_req.imm};
        nxt_res.pair_val = w;
        nxt_res.wr_pair  = 1'b1;
        nxt_res.sreg[alu_pkg::FLG_Z] = (w == 16'h0000);
        nxt_res.sreg[alu_pkg::FLG_N] = w[15];
        nxt_res.sreg[alu_pkg::FLG_V] = sub ? (i_req.pair[15] & ~w[15]) : (~i_req.pair[15] & w[15]);
        nxt_res.sreg[alu_pkg::FLG_C] = sub ? (w[15] & ~i_req.pair[15]) : (~w[15] & i_req.pair[15]);
        nxt_res.sreg[alu_pkg::FLG_S] = w[15] ^ nxt_res.sreg[alu_pkg::FLG_V];
        nxt_clocks = alu_pkg::CLK_TWO;
      end
      alu_pkg::op_relative_jump, alu_pkg::op_relative_call: begin
        nxt_res.pc      = (i_req.pc + i_req.offs + 16'h0001) & pc_mask;
        nxt_res.pc_load = 1'b1;
        nxt_clocks = (i_req.op == alu_pkg::op_relative_call) ? alu_pkg::CLK_CALL : alu_pkg::CLK_TWO;
      end
      alu_pkg::op_pointer_jump: begin
        nxt_res.pc      = i_req.zptr & pc_mask;
        nxt_res.pc_load = 1'b1;
        nxt_clocks      = alu_pkg::CLK_TWO;
      end
      default: nxt_clocks = is_mult ? alu_pkg::CLK_TWO : alu_pkg::CLK_SHORT;
    endcase
    if (arith) begin
      r = sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
      if (sub) begin
        nxt_res.sreg[alu_pkg::FLG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        nxt_res.sreg[alu_pkg::FLG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        nxt_res.sreg[alu_pkg::FLG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      end else begin
        nxt_res.sreg[alu_pkg::FLG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        nxt_res.sreg[alu_pkg::FLG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        nxt_res.sreg[alu_pkg::FLG_C] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      end
    end
    if (logic_op) begin
      nxt_res.sreg[alu_pkg::FLG_V] = 1'b0;
    end
    if (arith || logic_op) begin
      nxt_res.dst_val = r;
      nxt_res.wr_dst  = 1'b1;
      nxt_res.sreg[alu_pkg::FLG_Z] = (r == 8'h00);
      nxt_res.sreg[alu_pkg::FLG_N] = r[7];
      nxt_res.sreg[alu_pkg::FLG_S] = r[7] ^ nxt_res.sreg[alu_pkg::FLG_V];
    end
  end

  // Product shaping in the second clock of a multiply
  always_comb begin
    mres = pend_frac_ff ? {prod[14:0], 1'b0} : prod;
  end

  // Multi-cycle hold and count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_ff      <= 1'b0;
      cnt_ff       <= 2'h0;
      pend_ff      <= '0;
      pend_mult_ff <= 1'b0;
      pend_frac_ff <= 1'b0;
      pend_sreg_ff <= alu_pkg::SREG_RST;
    end else if (accept && nxt_clocks != alu_pkg::CLK_SHORT) begin
      busy_ff      <= 1'b1;
      cnt_ff       <= nxt_clocks - 2'h1;
      pend_ff      <= nxt_res;
      pend_mult_ff <= is_mult;
      pend_frac_ff <= is_frac;
      pend_sreg_ff <= i_req.sreg;
    end else if (busy_ff) begin
      cnt_ff  <= cnt_ff - 2'h1;
      busy_ff <= (cnt_ff != 2'h1);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ready <= 1'b1;
    end else if (accept && nxt_clocks != alu_pkg::CLK_SHORT) begin
      o_ready <= 1'b0;
    end else if (busy_ff && cnt_ff == 2'h1) begin
      o_ready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
      o_res  <= '0;
    end else if (accept && nxt_clocks == alu_pkg::CLK_SHORT) begin
      o_done <= 1'b1;
      o_res  <= nxt_res;
    end else if (busy_ff && cnt_ff == 2'h1) begin
      o_done <= 1'b1;
      o_res  <= pend_ff;
      if (pend_mult_ff) begin
        o_res.pair_val <= mres;
        o_res.wr_r1r0  <= 1'b1;
        o_res.sreg     <= pend_sreg_ff;
        o_res.sreg[alu_pkg::FLG_C] <= prod[15];
        o_res.sreg[alu_pkg::FLG_Z] <= (mres == 16'h0000);
      end
    end else begin
      o_done <= 1'b0;
    end
  end

  a_add_sum: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_add |=> o_done && o_res.dst_val == 8'($past(i_req.dst) + $past(i_req.src)))
    else $error("add result wrong");
  a_word_add_two: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_add_imm_word |=> !o_done ##1 (o_done && o_res.wr_pair &&
      o_res.pair_val == $past(i_req.pair, 2) + {8'h00, $past(i_req.imm, 2)}))
    else $error("word add wrong");
  a_sub_const: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_sub_const |=> o_done && o_res.dst_val == 8'($past(i_req.dst) - $past(i_req.imm)))
    else $error("subtract wrong");
  a_sub_carry_val: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_sub_regs_carry |=>
      o_res.dst_val == 8'($past(i_req.dst) - $past(i_req.src) - {7'h00, $past(i_req.sreg[0])}))
    else $error("subtract with carry wrong");
  a_word_sub_c: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_sub_imm_word && i_req.pair < {8'h00, i_req.imm} |-> ##2 o_done && o_res.sreg[0])
    else $error("word subtract borrow wrong");
  a_and_keeps_c: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_and_regs |=> o_res.sreg[alu_pkg::FLG_C] == $past(i_req.sreg[0]) &&
      !o_res.sreg[alu_pkg::FLG_V])
    else $error("logic flags wrong");
  a_clear_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_clear_mask_bits |=> (o_res.dst_val & $past(i_req.imm)) == 8'h00)
    else $error("clear bits left set");
  a_mult_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_mult_unsigned |-> ##2 o_done && o_res.wr_r1r0 &&
      o_res.pair_val == 16'($past(i_req.dst, 2) * $past(i_req.src, 2)))
    else $error("multiply product wrong");
  a_call_three: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_relative_call |=> !o_done ##1 !o_done ##1 (o_done && o_res.pc_load))
    else $error("call timing wrong");
  a_ptr_jump: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == alu_pkg::op_pointer_jump |-> ##2 o_done && o_res.sreg == $past(i_req.sreg, 2))
    else $error("pointer jump touched flags");
endmodule // eight_bit_alu_and_jumps

// ---- tb/core_side_model.sv ----
`timescale 1ns/10ps
module core_side_model (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_valid,
  input  wire logic        i_ready,
  input  wire logic        i_done,
  output logic      [3:0]  o_since_take,
  output logic      [15:0] o_dones
);
  logic [3:0]  since_ff;
  logic [15:0] dones_ff;

  // Edges since the decoder's last accepted request
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_ff <= 4'h0;
    end else if (i_valid && i_ready) begin
      since_ff <= 4'h1;
    end else if (since_ff != 4'hf) begin
      since_ff <= since_ff + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dones_ff <= 16'h0;
    end else if (i_done) begin
      dones_ff <= dones_ff + 16'h1;
    end
  end

  assign o_since_take = since_ff;
  assign o_dones      = dones_ff;
endmodule // core_side_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  localparam int PC_W = 10;
  localparam int REQ_W = $bits(alu_pkg::req_t);
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_valid = 1'b0;
  alu_pkg::req_t i_req = '0;
  logic o_ready, o_done;
  alu_pkg::res_t o_res, e, e2;
  logic [3:0]  since, lat;
  logic [15:0] dones, d0;
  alu_pkg::req_t q, corner[12];
  int bad_count = 0;
  int checked = 0;

  always #5 i_clk = ~i_clk;

  eight_bit_alu_and_jumps #(.PC_W(PC_W)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
    .i_req(i_req), .o_ready(o_ready), .o_done(o_done), .o_res(o_res));
  core_side_model i_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_ready(o_ready),
    .i_done(o_done), .o_since_take(since), .o_dones(dones));

  function automatic alu_pkg::res_t model(alu_pkg::req_t q, output logic [3:0] lat);
    alu_pkg::res_t e;
    logic [7:0] d, b, r, dd, rr, bb;
    logic [15:0] w, p, m;
    logic sub, cin, sa, sb;
    e = '0; e.sreg = q.sreg; lat = 4'h1; d = q.dst;
    m = 16'((32'h1 << PC_W) - 1);
    sub = q.op inside {alu_pkg::op_sub_regs, alu_pkg::op_sub_const, alu_pkg::op_sub_regs_carry,
                       alu_pkg::op_sub_const_carry, alu_pkg::op_sub_imm_word};
    cin = (q.op inside {alu_pkg::op_add_carry, alu_pkg::op_sub_regs_carry, alu_pkg::op_sub_const_carry})
          & q.sreg[alu_pkg::FLG_C];
    b = (q.op inside {alu_pkg::op_sub_const, alu_pkg::op_sub_const_carry, alu_pkg::op_and_const,
         alu_pkg::op_or_const, alu_pkg::op_set_mask_bits, alu_pkg::op_clear_mask_bits}) ? q.imm : q.src;
    r = sub ? d - b - 8'(cin) : d + b + 8'(cin);
    dd = sub ? ~d : d; rr = sub ? ~r : r; bb = sub ? ~b : b;
    sa = q.op inside {alu_pkg::op_mult_signed, alu_pkg::op_mult_signed_unsigned, alu_pkg::op_frac_mult_signed,
                      alu_pkg::op_frac_mult_signed_unsigned};
    sb = q.op inside {alu_pkg::op_mult_signed, alu_pkg::op_frac_mult_signed};
    p = 16'($signed({sa & d[7], d}) * $signed({sb & q.src[7], q.src}));
    case (q.op)
      alu_pkg::op_add, alu_pkg::op_add_carry, alu_pkg::op_sub_regs, alu_pkg::op_sub_const,
      alu_pkg::op_sub_regs_carry, alu_pkg::op_sub_const_carry: begin
        e.sreg[alu_pkg::FLG_C] = dd[7] & b[7] | b[7] & ~rr[7] | ~rr[7] & dd[7];
        e.sreg[alu_pkg::FLG_H] = dd[3] & b[3] | b[3] & ~rr[3] | ~rr[3] & dd[3];
        e.sreg[alu_pkg::FLG_V] = d[7] & bb[7] & ~r[7] | ~d[7] & ~bb[7] & r[7];
        e.wr_dst = 1'b1;
      end
      alu_pkg::op_and_regs, alu_pkg::op_and_const, alu_pkg::op_or_regs, alu_pkg::op_or_const,
      alu_pkg::op_xor_regs, alu_pkg::op_set_mask_bits, alu_pkg::op_clear_mask_bits,
      alu_pkg::op_test_zero_minus: begin
        case (q.op)
          alu_pkg::op_and_regs, alu_pkg::op_and_const: r = d & b;
          alu_pkg::op_xor_regs: r = d ^ b;
          alu_pkg::op_clear_mask_bits: r = d & (alu_pkg::BYTE_ONES - b);
          alu_pkg::op_test_zero_minus: r = d & d;
          default: r = d | b;
        endcase
        e.sreg[alu_pkg::FLG_V] = 1'b0;
        e.wr_dst = 1'b1;
      end
      alu_pkg::op_add_imm_word, alu_pkg::op_sub_imm_word: begin
        w = sub ? q.pair - {8'h0, q.imm} : q.pair + {8'h0, q.imm};
        e.sreg[alu_pkg::FLG_V] = sub ? q.pair[15] & ~w[15] : ~q.pair[15] & w[15];
        e.sreg[alu_pkg::FLG_C] = sub ? ~q.pair[15] & w[15] : q.pair[15] & ~w[15];
        e.sreg[alu_pkg::FLG_N] = w[15];
        e.sreg[alu_pkg::FLG_Z] = w == 16'h0;
        e.sreg[alu_pkg::FLG_S] = w[15] ^ e.sreg[alu_pkg::FLG_V];
        e.pair_val = w; e.wr_pair = 1'b1; lat = 4'h2;
      end
      alu_pkg::op_relative_jump, alu_pkg::op_relative_call: begin
        e.pc = (q.pc + q.offs + 16'h1) & m; e.pc_load = 1'b1;
        lat = (q.op == alu_pkg::op_relative_call) ? 4'h3 : 4'h2;
      end
      alu_pkg::op_pointer_jump: begin
        e.pc = q.zptr & m; e.pc_load = 1'b1; lat = 4'h2;
      end
      default: begin
        e.pair_val = (q.op >= alu_pkg::op_frac_mult_unsigned) ? p << 1 : p;
        e.sreg[alu_pkg::FLG_C] = p[15];
        e.sreg[alu_pkg::FLG_Z] = e.pair_val == 16'h0;
        e.wr_r1r0 = 1'b1; lat = 4'h2;
      end
    endcase
    if (e.wr_dst) begin
      e.dst_val = r;
      e.sreg[alu_pkg::FLG_N] = r[7];
      e.sreg[alu_pkg::FLG_Z] = r == 8'h0;
      e.sreg[alu_pkg::FLG_S] = r[7] ^ e.sreg[alu_pkg::FLG_V];
    end
    return e;
  endfunction

  function automatic alu_pkg::req_t mk(alu_pkg::op_t op, logic [7:0] d, s, i, logic [15:0] pr, logic [7:0] sr);
    alu_pkg::req_t q;
    q = '{op: op, dst: d, src: s, imm: i, pair: pr, pc: pr, offs: pr, zptr: pr, sreg: sr};
    return q;
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_for(input bit want_done);
    for (int n = 0; n < 20; n++) begin
      if ((want_done ? o_done : o_ready) === 1'b1) return;
      @(negedge i_clk);
    end
    bad_count++;
    print_verdict();
  endtask

  task automatic run(input alu_pkg::req_t q);
    e = model(q, lat);
    @(negedge i_clk);
    wait_for(1'b0);
    i_valid = 1'b1;
    i_req = q;
    @(negedge i_clk);
    i_valid = 1'b0;
    wait_for(1'b1);
    cmp(16'(since), 16'(lat));
    cmp(16'(o_res.sreg), 16'(e.sreg));
    cmp(16'({o_res.wr_dst, o_res.wr_pair, o_res.wr_r1r0, o_res.pc_load}),
        16'({e.wr_dst, e.wr_pair, e.wr_r1r0, e.pc_load}));
    if (e.wr_dst) cmp(16'(o_res.dst_val), 16'(e.dst_val));
    if (e.wr_pair) cmp(16'(o_res.wr_pair), 16'h1);
    if (e.wr_pair | e.wr_r1r0) cmp(o_res.pair_val, e.pair_val);
    if (e.pc_load) cmp(o_res.pc, e.pc);
  endtask

  initial begin
    void'($urandom(15508));
    corner = '{mk(alu_pkg::op_add, 8'h0f, 8'h01, 8'h00, 16'h0, 8'h00),
               mk(alu_pkg::op_add_carry, 8'hff, 8'h00, 8'h00, 16'h0, 8'h01),
               mk(alu_pkg::op_sub_regs, 8'h00, 8'h01, 8'h00, 16'h0, 8'h00),
               mk(alu_pkg::op_sub_const_carry, 8'h80, 8'h00, 8'h00, 16'h0, 8'h01),
               mk(alu_pkg::op_add_imm_word, 8'h00, 8'h00, 8'h01, 16'hffff, 8'h00),
               mk(alu_pkg::op_sub_imm_word, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h00),
               mk(alu_pkg::op_frac_mult_signed, 8'h80, 8'h80, 8'h00, 16'h0, 8'h00),
               mk(alu_pkg::op_mult_signed_unsigned, 8'hff, 8'hff, 8'h00, 16'h0, 8'h00),
               mk(alu_pkg::op_clear_mask_bits, 8'hff, 8'h00, 8'h0f, 16'h0, 8'h21),
               mk(alu_pkg::op_test_zero_minus, 8'h00, 8'h00, 8'h00, 16'h0, 8'h3f),
               mk(alu_pkg::op_relative_call, 8'h00, 8'h00, 8'h00, 16'h03ff, 8'h00),
               mk(alu_pkg::op_pointer_jump, 8'h00, 8'h00, 8'h00, 16'hffff, 8'h00)};
    repeat (2) @(negedge i_clk);
    cmp(16'({o_ready, o_done, o_res === '0}), 16'h5);
    i_sys_rst = 1'b0;
    foreach (corner[k]) run(corner[k]);
    for (int n = 0; n < 300; n++) begin
      q = alu_pkg::req_t'(REQ_W'({$urandom(), $urandom(), $urandom(), $urandom()}));
      q.op = alu_pkg::op_t'(5'($urandom_range(0, 24)));
      run(q);
    end
    // Two one-clock ops back to back
    e = model(corner[0], lat);
    e2 = model(corner[2], lat);
    @(negedge i_clk);
    i_valid = 1'b1;
    i_req = corner[0];
    @(negedge i_clk);
    i_req = corner[2];
    cmp(16'({o_done, o_res.dst_val}), 16'({1'b1, e.dst_val}));
    @(negedge i_clk);
    i_valid = 1'b0;
    cmp(16'({o_done, o_res.dst_val}), 16'({1'b1, e2.dst_val}));
    // Request offered while a multiply runs is not taken
    @(negedge i_clk);
    d0 = dones;
    i_valid = 1'b1;
    i_req = corner[7];
    @(negedge i_clk);
    i_req = corner[0];
    @(negedge i_clk);
    i_valid = 1'b0;
    repeat (3) @(negedge i_clk);
    cmp(dones - d0, 16'h1);
    cmp(16'(o_res.wr_r1r0), 16'h1);
    // Reset in the middle of a call
    @(negedge i_clk);
    i_valid = 1'b1;
    i_req = corner[10];
    @(negedge i_clk);
    i_valid = 1'b0;
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    cmp(16'({o_ready, o_done, o_res === '0}), 16'h5);
    i_sys_rst = 1'b0;
    run(corner[0]);
    print_verdict();
  end
endmodule // tb
